// >>> hdl/cpma_buf.sv
// Small FIFO with valid and ready on both sides
`timescale 1ns/1ps

module cpma_buf #(
  parameter int WIDTH = 93,
  parameter int DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("cpma_buf: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic [PW:0] cnt_d;
  logic rdy_q;
  wire push;
  wire pop;

  // Ready is registered so the link never sees a combinational path
  assign push = in_valid & rdy_q;
  assign pop = out_valid & out_ready;
  assign cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
  assign in_ready = rdy_q;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];

  // Pointers and fill level
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      wr_q <= wr_q + PW'(push);
      rd_q <= rd_q + PW'(pop);
      cnt_q <= cnt_d;
      rdy_q <= (cnt_d != (PW+1)'(DEPTH));
    end
  end

  // Storage needs no reset
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule

// >>> hdl/cpma_cfg.svh
// Constants of the CAN parameter-map agent: groups, field positions, timing
`ifndef CPMA_CFG_SVH
`define CPMA_CFG_SVH

// Group numbers carried in identifier bits 23:8
`define CPMA_PGN_SPEED 16'hFF90
`define CPMA_PGN_MIN_SPEED 16'hFF91
`define CPMA_PGN_MAX_SPEED 16'hFF92
`define CPMA_PGN_VPT 16'hFF93
`define CPMA_PGN_HOURS_FUEL 16'hFF94
`define CPMA_PGN_STATE 16'hFF95
`define CPMA_PGN_RUN 16'hFF96
`define CPMA_PGN_SAVE 16'hFFBB

// Identifier fields
`define CPMA_PRIO 5'h18
`define CPMA_CMD_SA 8'h70
`define CPMA_ID_PRIO_LO 24
`define CPMA_ID_PGN_LO 8
`define CPMA_ID_SA_LO 0

// Data field start bits, least significant byte first
`define CPMA_SIG_LO 0
`define CPMA_FA_LO 16
`define CPMA_FB_LO 32
`define CPMA_FC_LO 48
`define CPMA_TMR_LO 24
`define CPMA_RUN_BIT 16
`define CPMA_SAVE_BIT 16

// Reset values of the writable fields
`define CPMA_MIN_SPEED_RST 16'h0000
`define CPMA_MAX_SPEED_RST 16'hFFFF
`define CPMA_RUN_RST 1'b0

// Timing
`define CPMA_CLK_KHZ 100000
`define CPMA_BCAST_PERIOD_MS 1000

`endif

// >>> hdl/cpma_dev.sv
// Device end: periodic status broadcast and command decode
`timescale 1ns/1ps
`include "cpma_cfg.svh"

// Overview of operation
// - Fields are raw integers, unit scale, zero offset
// - Sent groups start with the transmit signature
// - Commands reuse group number, carry command signature
// - Command identifier priority field is 18 hex
// - Command identifier source address is 70 hex
// - Save group bit 16 commits values
// - Save fires only on zero-to-one transition
// - All status groups broadcast once per second
// - No broadcast started or command obeyed unless map enabled
// - Voltage, oil pressure, temperature in group 93
// - Controller state code in bits 16-23
// - State timer seconds in bits 24-39
// - Run bit writable, start zero, readable
module cpma_dev #(
  parameter int BCAST_CYC = `CPMA_BCAST_PERIOD_MS * `CPMA_CLK_KHZ,
  parameter logic [7:0] TX_SIG0 = 8'h5C, // Arbitrary value
  parameter logic [7:0] TX_SIG1 = 8'h3E, // Arbitrary value
  parameter logic [7:0] CMD_SIG0 = 8'h6D, // Arbitrary value
  parameter logic [7:0] CMD_SIG1 = 8'h3E, // Arbitrary value
  parameter logic [7:0] DEV_SA = 8'h00,
  parameter int BUF_DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic nrst,
  cpma_if.dev link,
  input wire logic map_enable,
  input wire logic [15:0] engine_speed,
  input wire logic [15:0] target_speed,
  input wire logic [15:0] supply_decivolt,
  input wire logic [15:0] oil_pressure_kpa,
  input wire logic [15:0] engine_temp_c,
  input wire logic [31:0] engine_hours,
  input wire logic [15:0] fuel_level_pct,
  input wire cpma_pkg::cpma_ctrl_state_e ctrl_state,
  input wire logic [15:0] state_timer_s,
  output logic [15:0] min_speed_q,
  output logic [15:0] max_speed_q,
  output logic run_cmd_q,
  output logic nv_commit_q
);
  localparam int FW = 29 + 64;
  localparam logic [2:0] LAST_GRP = 3'h6;

  if (BCAST_CYC < 1) begin : g_chk
    $error("cpma_dev: BCAST_CYC must be at least 1");
  end

  //--------------------------------------------------------------
  // Broadcast period divider
  //--------------------------------------------------------------
  logic [31:0] per_q;
  logic tick_q;

  // One-cycle enable every period; counting runs even when disabled
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      per_q <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (per_q == 32'(BCAST_CYC - 1));
      per_q <= (per_q == 32'(BCAST_CYC - 1)) ? 32'h0 : per_q + 32'h1;
    end
  end

  //--------------------------------------------------------------
  // Status group contents
  //--------------------------------------------------------------
  cpma_pkg::cpma_dev_st_e st_q;
  cpma_pkg::cpma_dev_st_e st_d;
  logic [2:0] grp_q;
  logic tx_valid_q;
  cpma_pkg::cpma_id_t tx_id_q;
  cpma_pkg::cpma_data_t tx_data_q;
  wire [2:0] grp_sel;
  wire [15:0] ld_pgn;
  logic [63:0] ld_body;
  wire [63:0] ld_data;
  wire tx_take;
  wire start;
  wire load;

  // Group number of each slot in the broadcast sequence
  function automatic logic [15:0] grp_pgn(input logic [2:0] idx);
    case (idx)
      3'h0: grp_pgn = `CPMA_PGN_SPEED;
      3'h1: grp_pgn = `CPMA_PGN_MIN_SPEED;
      3'h2: grp_pgn = `CPMA_PGN_MAX_SPEED;
      3'h3: grp_pgn = `CPMA_PGN_VPT;
      3'h4: grp_pgn = `CPMA_PGN_HOURS_FUEL;
      3'h5: grp_pgn = `CPMA_PGN_STATE;
      default: grp_pgn = `CPMA_PGN_RUN;
    endcase
  endfunction

  // Values go out raw; bit n of the frame is data[n], byte k is data[8k+7:8k]
  function automatic logic [63:0] grp_body(input logic [2:0] idx);
    logic [63:0] b;
    b = 64'h0;
    case (idx)
      3'h0: begin
        b[`CPMA_FA_LO +: 16] = engine_speed;
        b[`CPMA_FB_LO +: 16] = target_speed;
      end
      3'h1: b[`CPMA_FA_LO +: 16] = min_speed_q;
      3'h2: b[`CPMA_FA_LO +: 16] = max_speed_q;
      3'h3: begin
        b[`CPMA_FA_LO +: 16] = supply_decivolt;
        b[`CPMA_FB_LO +: 16] = oil_pressure_kpa;
        b[`CPMA_FC_LO +: 16] = engine_temp_c;
      end
      3'h4: begin
        b[`CPMA_FA_LO +: 32] = engine_hours;
        b[`CPMA_FC_LO +: 16] = fuel_level_pct;
      end
      3'h5: begin
        b[`CPMA_FA_LO +: 8] = ctrl_state;
        b[`CPMA_TMR_LO +: 16] = state_timer_s;
      end
      default: b[`CPMA_RUN_BIT] = run_cmd_q;
    endcase
    grp_body = b;
  endfunction

  // Frame selection for the next load
  assign grp_sel = (st_q == cpma_pkg::CPMA_DEV_IDLE) ? 3'h0 : grp_q + 3'h1;
  assign ld_pgn = grp_pgn(grp_sel);
  always_comb ld_body = grp_body(grp_sel); // Process form wakes on the live inputs read inside
  assign ld_data = {ld_body[63:16], TX_SIG1, TX_SIG0};

  //--------------------------------------------------------------
  // Broadcast sequencer
  //--------------------------------------------------------------
  assign tx_take = tx_valid_q & link.dtx_ready;
  assign start = tick_q & map_enable & (st_q == cpma_pkg::CPMA_DEV_IDLE);
  assign load = start | (tx_take & (st_d == cpma_pkg::CPMA_DEV_SEND));

  // A frame on offer is never withdrawn; disabling ends after it
  always_comb begin
    st_d = st_q;
    case (st_q)
      cpma_pkg::CPMA_DEV_IDLE: begin
        if (start) begin
          st_d = cpma_pkg::CPMA_DEV_SEND;
        end
      end
      cpma_pkg::CPMA_DEV_SEND: begin
        if (tx_take && (grp_q == LAST_GRP || !map_enable)) begin
          st_d = cpma_pkg::CPMA_DEV_IDLE;
        end
      end
      default: st_d = cpma_pkg::CPMA_DEV_IDLE;
    endcase
  end

  // Frame registers; inputs are sampled at the load
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= cpma_pkg::CPMA_DEV_IDLE;
      grp_q <= 3'h0;
      tx_valid_q <= 1'b0;
      tx_id_q <= '0;
      tx_data_q <= '0;
    end else begin
      st_q <= st_d;
      tx_valid_q <= (st_d == cpma_pkg::CPMA_DEV_SEND);
      if (load) begin
        grp_q <= grp_sel;
        tx_id_q <= {`CPMA_PRIO, ld_pgn, DEV_SA};
        tx_data_q <= ld_data;
      end
    end
  end

  assign link.dtx_valid = tx_valid_q;
  assign link.dtx_id = tx_id_q;
  assign link.dtx_data = tx_data_q;

  //--------------------------------------------------------------
  // Command path
  //--------------------------------------------------------------
  wire [FW-1:0] b_data;
  wire b_valid;
  wire b_ready;
  cpma_pkg::cpma_id_t c_id;
  cpma_pkg::cpma_data_t c_data;
  wire [15:0] c_pgn;
  wire c_hdr_ok;
  wire c_ok;
  wire wr_min;
  wire wr_max;
  wire wr_run;
  wire wr_save;
  logic save_bit_q;

  // Commands wait here while a broadcast runs, so the link stalls, not drops
  cpma_buf #(
    .WIDTH(FW),
    .DEPTH(BUF_DEPTH)
  ) u_cmd_buf (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_valid(link.htx_valid),
    .in_ready(link.htx_ready),
    .in_data({link.htx_id, link.htx_data}),
    .out_valid(b_valid),
    .out_ready(b_ready),
    .out_data(b_data)
  );

  // Header check and group decode
  assign b_ready = (st_q == cpma_pkg::CPMA_DEV_IDLE);
  assign c_id = b_data[FW-1:64];
  assign c_data = b_data[63:0];
  assign c_pgn = c_id[`CPMA_ID_PGN_LO +: 16];
  assign c_hdr_ok = (c_id[`CPMA_ID_PRIO_LO +: 5] == `CPMA_PRIO)
    && (c_id[`CPMA_ID_SA_LO +: 8] == `CPMA_CMD_SA)
    && (c_data[`CPMA_SIG_LO +: 16] == {CMD_SIG1, CMD_SIG0});
  assign c_ok = b_valid & b_ready & map_enable & c_hdr_ok;
  assign wr_min = c_ok & (c_pgn == `CPMA_PGN_MIN_SPEED);
  assign wr_max = c_ok & (c_pgn == `CPMA_PGN_MAX_SPEED);
  assign wr_run = c_ok & (c_pgn == `CPMA_PGN_RUN);
  assign wr_save = c_ok & (c_pgn == `CPMA_PGN_SAVE);

  // Writable fields; any other group number leaves them alone
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      min_speed_q <= `CPMA_MIN_SPEED_RST;
      max_speed_q <= `CPMA_MAX_SPEED_RST;
      run_cmd_q <= `CPMA_RUN_RST;
    end else begin
      if (wr_min) begin
        min_speed_q <= c_data[`CPMA_FA_LO +: 16];
      end
      if (wr_max) begin
        max_speed_q <= c_data[`CPMA_FA_LO +: 16];
      end
      if (wr_run) begin
        run_cmd_q <= c_data[`CPMA_RUN_BIT];
      end
    end
  end

  // Save pulses only on a written one following reset or a written zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      save_bit_q <= 1'b0;
      nv_commit_q <= 1'b0;
    end else begin
      nv_commit_q <= wr_save & c_data[`CPMA_SAVE_BIT] & ~save_bit_q;
      if (wr_save) begin
        save_bit_q <= c_data[`CPMA_SAVE_BIT];
      end
    end
  end
endmodule

// >>> hdl/cpma_host.sv
// Commanding node end: sends command groups, receives status groups
`timescale 1ns/1ps
`include "cpma_cfg.svh"

module cpma_host #(
  parameter logic [7:0] TX_SIG0 = 8'h5C, // Arbitrary value
  parameter logic [7:0] TX_SIG1 = 8'h3E, // Arbitrary value
  parameter logic [7:0] CMD_SIG0 = 8'h6D, // Arbitrary value
  parameter logic [7:0] CMD_SIG1 = 8'h3E // Arbitrary value
) (
  input wire logic core_clk,
  input wire logic nrst,
  cpma_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready_q,
  input wire logic [15:0] cmd_pgn,
  input wire logic [47:0] cmd_value,
  output logic stat_valid_q,
  input wire logic stat_ready,
  output logic [15:0] stat_pgn_q,
  output logic [7:0] stat_src_q,
  output logic [47:0] stat_value_q
);
  //--------------------------------------------------------------
  // Command sender
  //--------------------------------------------------------------
  logic hv_q;
  cpma_pkg::cpma_id_t hid_q;
  cpma_pkg::cpma_data_t hdata_q;
  wire accept;
  wire sent;
  wire hv_d;

  assign accept = cmd_valid & cmd_ready_q;
  assign sent = hv_q & link.htx_ready;
  assign hv_d = accept | (hv_q & ~sent);

  // One frame in flight; fields go raw, low byte first
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hv_q <= 1'b0;
      cmd_ready_q <= 1'b0;
      hid_q <= '0;
      hdata_q <= '0;
    end else begin
      hv_q <= hv_d;
      cmd_ready_q <= ~hv_d;
      if (accept) begin
        hid_q <= {`CPMA_PRIO, cmd_pgn, `CPMA_CMD_SA};
        hdata_q <= {cmd_value, CMD_SIG1, CMD_SIG0};
      end
    end
  end

  assign link.htx_valid = hv_q;
  assign link.htx_id = hid_q;
  assign link.htx_data = hdata_q;

  //--------------------------------------------------------------
  // Status receiver
  //--------------------------------------------------------------
  logic rdy_q;
  wire take;
  wire sig_ok;

  // Frames without the transmit signature are consumed and dropped
  assign take = link.dtx_valid & rdy_q;
  assign sig_ok = (link.dtx_data[`CPMA_SIG_LO +: 16] == {TX_SIG1, TX_SIG0});

  // Holding register; ready drops while the user has not taken it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdy_q <= 1'b1;
      stat_valid_q <= 1'b0;
      stat_pgn_q <= 16'h0000;
      stat_src_q <= 8'h00;
      stat_value_q <= 48'h000000000000;
    end else begin
      if (take && sig_ok) begin
        rdy_q <= 1'b0;
        stat_valid_q <= 1'b1;
        stat_pgn_q <= link.dtx_id[`CPMA_ID_PGN_LO +: 16];
        stat_src_q <= link.dtx_id[`CPMA_ID_SA_LO +: 8];
        stat_value_q <= link.dtx_data[63:16];
      end else if (stat_valid_q && stat_ready) begin
        rdy_q <= 1'b1;
        stat_valid_q <= 1'b0;
      end
    end
  end

  assign link.dtx_ready = rdy_q;
endmodule

// >>> hdl/cpma_if.sv
// Frame link between the device end and the commanding node
`timescale 1ns/1ps

interface cpma_if;
  // Device to node: status groups
  logic dtx_valid;
  logic dtx_ready;
  cpma_pkg::cpma_id_t dtx_id;
  cpma_pkg::cpma_data_t dtx_data;
  // Node to device: command groups
  logic htx_valid;
  logic htx_ready;
  cpma_pkg::cpma_id_t htx_id;
  cpma_pkg::cpma_data_t htx_data;

  modport dev (
    output dtx_valid,
    input dtx_ready,
    output dtx_id,
    output dtx_data,
    input htx_valid,
    output htx_ready,
    input htx_id,
    input htx_data
  );

  modport host (
    input dtx_valid,
    output dtx_ready,
    input dtx_id,
    input dtx_data,
    output htx_valid,
    input htx_ready,
    output htx_id,
    output htx_data
  );
endinterface

// >>> hdl/cpma_pkg.sv
// Types shared by both ends of the CAN parameter-map agent
package cpma_pkg;

  typedef logic [28:0] cpma_id_t;
  typedef logic [63:0] cpma_data_t;

  // Controller state codes reported in the state group
  typedef enum logic [7:0] {
    CPMA_CS_STABILIZE = 8'h00,
    CPMA_CS_STOPPED = 8'h01,
    CPMA_CS_STANDBY = 8'h02,
    CPMA_CS_PRESTART1 = 8'h03,
    CPMA_CS_SAFE_CHECK = 8'h04,
    CPMA_CS_PRESTART2 = 8'h05,
    CPMA_CS_CRANK = 8'h06,
    CPMA_CS_CRANK_REST = 8'h07,
    CPMA_CS_FALSE_START = 8'h08,
    CPMA_CS_WARMUP = 8'h09,
    CPMA_CS_LINE_FILL1 = 8'h0A,
    CPMA_CS_LINE_FILL2 = 8'h0B,
    CPMA_CS_RUN_LOADED = 8'h0C,
    CPMA_CS_COOLDOWN = 8'h0D,
    CPMA_CS_ETS = 8'h0E,
    CPMA_CS_SPINDOWN = 8'h0F
  } cpma_ctrl_state_e;

  // Broadcast sequencer of the device end
  typedef enum logic {
    CPMA_DEV_IDLE = 1'b0,
    CPMA_DEV_SEND = 1'b1
  } cpma_dev_st_e;

endpackage

// >>> testbench/can_parameter_map_agent_tb.sv
// Self-checking bench: device end and commanding end back to back
`timescale 1ns/1ps
`include "cpma_cfg.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module can_parameter_map_agent_tb;
  localparam int BCAST = 200; // Short period keeps the run small
  logic core_clk, nrst, map_enable, cmd_valid, stat_ready;
  logic [15:0] engine_speed = 16'h0A1B, target_speed = 16'h0C2D;
  logic [15:0] supply_decivolt = 16'h007D, oil_pressure_kpa = 16'h01F4;
  logic [15:0] engine_temp_c = 16'h0055, fuel_level_pct = 16'h0042;
  logic [15:0] state_timer_s = 16'h0003;
  logic [31:0] engine_hours = 32'h0001_2345;
  cpma_pkg::cpma_ctrl_state_e ctrl_state = cpma_pkg::CPMA_CS_STOPPED;
  logic [15:0] cmd_pgn, min_e = 16'h0000, max_e = 16'hFFFF;
  logic [47:0] cmd_value;
  logic run_e = 1'b0;
  wire logic [15:0] min_speed_q, max_speed_q, stat_pgn_q;
  wire logic run_cmd_q, nv_commit_q, cmd_ready_q, stat_valid_q;
  wire logic [47:0] stat_value_q;
  wire logic [7:0] stat_src_q;
  int failures, n_tests, cyc, n_save, t_prev, i, k;
  logic [47:0] sv [4] = '{48'h1, 48'h1, 48'h1_0000_0000, 48'h1};
  int ns [4] = '{1, 1, 1, 2};

  cpma_if lk ();
  cpma_dev #(.BCAST_CYC(BCAST)) cpma_dev_i (.core_clk, .nrst, .link(lk), .map_enable,
    .engine_speed, .target_speed, .supply_decivolt, .oil_pressure_kpa, .engine_temp_c,
    .engine_hours, .fuel_level_pct, .ctrl_state, .state_timer_s, .min_speed_q,
    .max_speed_q, .run_cmd_q, .nv_commit_q);
  cpma_host cpma_host_i (.core_clk, .nrst, .link(lk), .cmd_valid, .cmd_ready_q, .cmd_pgn,
    .cmd_value, .stat_valid_q, .stat_ready, .stat_pgn_q, .stat_src_q, .stat_value_q);
  cpma_assertions cpma_assertions_i (.core_clk, .nrst, .dtx_valid(lk.dtx_valid),
    .dtx_ready(lk.dtx_ready), .dtx_id(lk.dtx_id), .dtx_data(lk.dtx_data),
    .htx_valid(lk.htx_valid), .htx_ready(lk.htx_ready), .htx_id(lk.htx_id),
    .htx_data(lk.htx_data));

  // ---------------------------------------------
  // Clock, cycle count and commit pulse count
  // ---------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Counting high cycles also catches a pulse wider than one cycle
  always @(posedge core_clk) begin
    cyc++;
    if (nv_commit_q === 1'b1) n_save++;
  end

  // ---------------------------------------------
  // Access tasks
  // ---------------------------------------------
  task wrap_up;
    $display("Comparisons: %0d, mismatches: %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task step(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask
  task bail;
    `CHK(1'b0, 1'b1)
    wrap_up();
  endtask
  // Leading idle cycle keeps cmd_valid from toggling twice in a step
  task send(input logic [15:0] p, input logic [47:0] v);
    logic t;
    int j;
    step(1);
    t = 1'b0;
    cmd_pgn = p;
    cmd_value = v;
    cmd_valid = 1'b1;
    for (j = 0; j < 500 && !t; j++) begin
      t = (cmd_ready_q === 1'b1);
      step(1);
    end
    cmd_valid = 1'b0;
    if (!t) bail();
  endtask
  task recv(output logic [15:0] p, output logic [47:0] v);
    int j;
    for (j = 0; j < 3000 && stat_valid_q !== 1'b1; j++) step(1);
    if (j == 3000) bail();
    p = stat_pgn_q;
    v = stat_value_q;
    step(1);
  endtask
  function automatic logic [47:0] expv(input logic [15:0] p);
    case (p)
      `CPMA_PGN_SPEED: return {16'h0000, target_speed, engine_speed};
      `CPMA_PGN_MIN_SPEED: return {32'h0, min_e};
      `CPMA_PGN_MAX_SPEED: return {32'h0, max_e};
      `CPMA_PGN_VPT: return {engine_temp_c, oil_pressure_kpa, supply_decivolt};
      `CPMA_PGN_HOURS_FUEL: return {fuel_level_pct, engine_hours};
      `CPMA_PGN_STATE: return {24'h0, state_timer_s, ctrl_state};
      default: return {47'h0, run_e};
    endcase
  endfunction
  // Syncs on the speed group, then takes the other six in order
  task check_bcast(input logic per);
    logic [15:0] p;
    logic [47:0] v;
    int j;
    p = 16'h0000;
    for (j = 0; j < 9 && p !== `CPMA_PGN_SPEED; j++) recv(p, v);
    if (p !== `CPMA_PGN_SPEED) bail();
    if (per) `CHK(cyc - t_prev, BCAST)
    t_prev = cyc;
    `CHK(v, expv(p))
    `CHK(stat_src_q, 8'h00)
    for (j = 1; j < 7; j++) begin
      recv(p, v);
      `CHK(p, `CPMA_PGN_SPEED + 16'(j))
      `CHK(v, expv(p))
    end
  endtask

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    nrst = 1'b0;
    map_enable = 1'b1;
    cmd_valid = 1'b0;
    stat_ready = 1'b1;
    cmd_pgn = 16'h0000;
    cmd_value = 48'h0;
    repeat (6) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    `CHK(max_speed_q, 16'hFFFF)
    check_bcast(1'b0);
    // Stall the receiver mid-broadcast and fill the command buffer
    for (i = 0; i < 400 && lk.dtx_valid !== 1'b1; i++) step(1);
    if (i == 400) bail();
    stat_ready = 1'b0;
    send(`CPMA_PGN_MIN_SPEED, 48'h1234);
    send(`CPMA_PGN_MAX_SPEED, 48'hABCD);
    send(`CPMA_PGN_RUN, 48'h1);
    step(3);
    `CHK(lk.htx_ready, 1'b0)
    `CHK(lk.htx_valid, 1'b1)
    stat_ready = 1'b1;
    check_bcast(1'b0);
    step(20);
    min_e = 16'h1234;
    max_e = 16'hABCD;
    run_e = 1'b1;
    `CHK({min_speed_q, max_speed_q, run_cmd_q}, {min_e, max_e, run_e})
    check_bcast(1'b0);
    // Disabled map: no broadcast, commands dropped
    map_enable = 1'b0;
    send(`CPMA_PGN_MIN_SPEED, 48'h0055);
    send(`CPMA_PGN_RUN, 48'h0);
    k = 0;
    for (i = 0; i < 2 * BCAST; i++) begin
      if (lk.dtx_valid === 1'b1) k++;
      step(1);
    end
    `CHK(k, 0)
    `CHK({min_speed_q, run_cmd_q}, {min_e, run_e})
    map_enable = 1'b1;
    // Read-only and unknown groups leave the stored values alone
    send(`CPMA_PGN_SPEED, 48'hFFFF);
    send(16'hFF97, 48'h0);
    step(20);
    `CHK({min_speed_q, max_speed_q, run_cmd_q}, {min_e, max_e, run_e})
    // Save: only a zero-to-one of bit 16 commits; bit 48 is not the save bit
    for (i = 0; i < 4; i++) begin
      send(`CPMA_PGN_SAVE, sv[i]);
      step(20);
      `CHK(n_save, ns[i])
    end
    send(`CPMA_PGN_RUN, 48'h0);
    run_e = 1'b0;
    step(20);
    `CHK(run_cmd_q, run_e)
    // Every state code, back-to-back broadcasts
    for (i = 0; i < 16; i++) begin
      ctrl_state = cpma_pkg::cpma_ctrl_state_e'(i[7:0]);
      state_timer_s = 16'h0100 + 16'(i);
      check_bcast(i > 0);
    end
    wrap_up();
  end
endmodule

// >>> testbench/cpma_assertions.sv
// Protocol checker for the frame link between both agent ends
`timescale 1ns/1ps
`include "cpma_cfg.svh"

module cpma_assertions #(
  parameter logic [7:0] TX_SIG0 = 8'h5C, // Arbitrary value
  parameter logic [7:0] TX_SIG1 = 8'h3E, // Arbitrary value
  parameter logic [7:0] CMD_SIG0 = 8'h6D, // Arbitrary value
  parameter logic [7:0] CMD_SIG1 = 8'h3E // Arbitrary value
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic dtx_valid,
  input wire logic dtx_ready,
  input wire cpma_pkg::cpma_id_t dtx_id,
  input wire cpma_pkg::cpma_data_t dtx_data,
  input wire logic htx_valid,
  input wire logic htx_ready,
  input wire cpma_pkg::cpma_id_t htx_id,
  input wire cpma_pkg::cpma_data_t htx_data
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // Group number and take strobe of the status direction
  wire logic [15:0] dpgn = dtx_id[23:8];
  wire logic dtake = dtx_valid && dtx_ready;

  // ---------------------------------------------
  // Status direction
  // ---------------------------------------------
  property p_dtx_prio;
    dtx_valid |-> dtx_id[28:24] == `CPMA_PRIO;
  endproperty
  a_dtx_prio: assert property (p_dtx_prio) else $error("status priority wrong");
  property p_dtx_sig;
    dtx_valid |-> dtx_data[15:0] == {TX_SIG1, TX_SIG0};
  endproperty
  a_dtx_sig: assert property (p_dtx_sig) else $error("status signature wrong");
  // A stalled frame must not change under the receiver
  property p_dtx_hold;
    dtx_valid && !dtx_ready |=> dtx_valid && $stable(dtx_id) && $stable(dtx_data);
  endproperty
  a_dtx_hold: assert property (p_dtx_hold) else $error("status frame moved");
  property p_seq_start;
    $rose(dtx_valid) |-> dpgn == `CPMA_PGN_SPEED;
  endproperty
  a_seq_start: assert property (p_seq_start) else $error("sequence start wrong");
  property p_seq_next;
    dtake && dpgn != `CPMA_PGN_RUN |=> dtx_valid && dpgn == $past(dpgn) + 16'h0001;
  endproperty
  a_seq_next: assert property (p_seq_next) else $error("group order wrong");
  // No new sequence can start right after the last group
  property p_seq_end;
    dtake && dpgn == `CPMA_PGN_RUN |=> !dtx_valid [*8];
  endproperty
  a_seq_end: assert property (p_seq_end) else $error("sequence did not stop");
  property p_run_pad;
    dtx_valid && dpgn == `CPMA_PGN_RUN |-> dtx_data[63:17] == 47'h0;
  endproperty
  a_run_pad: assert property (p_run_pad) else $error("run group padding");
  property p_state_fmt;
    dtx_valid && dpgn == `CPMA_PGN_STATE |-> dtx_data[23:20] == 4'h0 && dtx_data[63:40] == 24'h0;
  endproperty
  a_state_fmt: assert property (p_state_fmt) else $error("state group format");

  // ---------------------------------------------
  // Command direction
  // ---------------------------------------------
  property p_cmd_prio;
    htx_valid |-> htx_id[28:24] == `CPMA_PRIO;
  endproperty
  a_cmd_prio: assert property (p_cmd_prio) else $error("command priority wrong");
  property p_cmd_sa;
    htx_valid |-> htx_id[7:0] == `CPMA_CMD_SA;
  endproperty
  a_cmd_sa: assert property (p_cmd_sa) else $error("command source wrong");
  property p_cmd_sig;
    htx_valid |-> htx_data[15:0] == {CMD_SIG1, CMD_SIG0};
  endproperty
  a_cmd_sig: assert property (p_cmd_sig) else $error("command signature wrong");
  property p_cmd_hold;
    htx_valid && !htx_ready |=> htx_valid && $stable(htx_id) && $stable(htx_data);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command frame moved");

  // Main scenarios reached
  c_bcast_done: cover property (dtake && dpgn == `CPMA_PGN_RUN);
  c_bcast_stall: cover property (dtx_valid && !dtx_ready);
  c_cmd_take: cover property (htx_valid && htx_ready);
  c_cmd_full: cover property (htx_valid && !htx_ready);
endmodule
